// file: core/twowire_pkg.sv
// Constants for the two-wire acknowledge, wait and clock-level control block.
package twowire_pkg;
	localparam int          ADDR_W        = 18;
	localparam int          CLK_PERIOD_NS = 4;
	localparam int          SCL_HALF_NS   = 2000;
	localparam int          SCL_HALF_CYC  = SCL_HALF_NS / CLK_PERIOD_NS;
	// Register indices; the byte address is four times the index.
	localparam logic [15:0] CTRL_IDX      = 16'hFF60;
	localparam logic [15:0] SBC_IDX       = 16'hFF61;
	localparam logic [15:0] ITC_IDX       = 16'hFF63;
	localparam logic [15:0] DATA_IDX      = 16'hFF64;
	localparam logic [15:0] SADDR_IDX     = 16'hFF65;
	localparam logic [15:0] STATUS_IDX    = 16'hFF66;
	localparam logic [17:0] CTRL_ADDR     = {CTRL_IDX, 2'h0};
	localparam logic [17:0] SBC_ADDR      = {SBC_IDX, 2'h0};
	localparam logic [17:0] ITC_ADDR      = {ITC_IDX, 2'h0};
	localparam logic [17:0] DATA_ADDR     = {DATA_IDX, 2'h0};
	localparam logic [17:0] SADDR_ADDR    = {SADDR_IDX, 2'h0};
	localparam logic [17:0] STATUS_ADDR   = {STATUS_IDX, 2'h0};
	localparam logic [7:0]  REG_RESET     = 8'h00;
	localparam int          CTRL_ENABLE   = 7;
	localparam int          CTRL_MASTER   = 0;
	localparam int          SBC_BUSY_EN   = 7;
	localparam int          SBC_ACK_DET   = 6;
	localparam int          SBC_AUTO_ACK  = 5;
	localparam int          SBC_ACK_TX    = 4;
	localparam int          ITC_CLK_LVL   = 6;
	localparam int          ITC_IRQ_SRC   = 5;
	localparam int          ITC_ADDR_MASK = 4;
	localparam int          ITC_CLK_CTRL  = 3;
	localparam int          ITC_WAIT_REL  = 2;
	localparam int          ITC_WAIT_HI   = 1;
	localparam int          ITC_WAIT_LO   = 0;
	localparam int          ST_BUSY       = 0;
	localparam int          ST_MATCH      = 1;
	localparam int          ST_WAIT       = 2;
	localparam logic [3:0]  CNT_BIT7      = 4'h7;
	localparam logic [3:0]  CNT_BYTE      = 4'h8;
	localparam logic [3:0]  CNT_ACK       = 4'h9;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [1:0] {
		WAIT_NONE = 2'h0,
		WAIT_BAD  = 2'h1,
		WAIT_8    = 2'h2,
		WAIT_9    = 2'h3
	} wait_mode_e;

	typedef enum logic [1:0] {
		XF_IDLE = 2'h0,
		XF_DATA = 2'h1,
		XF_ACK  = 2'h3
	} xfer_state_e;
endpackage

// file: core/twowire_ack_wait_control.sv
// Acknowledge, wait, clock-level and address control of a two-wire serial channel.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
// Notes on behaviour
// - Writing ack_transmit 1 pulls data low until the next bus clock fall.
// - ack_transmit clears on transfer start or when the channel is disabled.
// - In 8- and 9-clock wait, automatic acknowledge is driven from the 8th clock fall until the 9th clock fall.
// - auto_ack_enable is never cleared by hardware.
// - ack_detected sets when acknowledge is sampled at the 9th clock rise.
// - ack_detected clears on transfer start, channel disable or reset.
// - busy_enable 0 lets data drive; 1 blocks it for reception.
// - Transfer start releases the wait and leaves busy_enable unchanged.
// - Wait field 00 interrupts at the 8th rise without a wait; 01 prohibited.
// - 8-clock wait: interrupt at the 8th rise, then hold clock low.
// - 9-clock wait: interrupt at the 9th rise, then hold clock low.
// - Writing wait_release 1 ends the wait; the bit reads back 0.
// - clock_level_ctrl 0 drives the clock low while the channel is enabled and no transfer runs.
// - clock_level_ctrl 1 lets the idle clock float high.
// - address_mask 0 compares all eight address bits, 1 compares bits 7..1.
// - interrupt_source_sel 1 adds stop detection as an interrupt source.
// - clock_pin_level shows the clock pin and reads 0 when disabled.
// - channel_enable 0 stops the channel; 1 lets it run.
module twowire_ack_wait_control
	import twowire_pkg::*;
#(
	parameter int HALF_CYC = SCL_HALF_CYC
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              scl_i,
	output logic                   scl_o,
	output logic                   scl_oe,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe,
	output logic                   channel_interrupt
);

	localparam int DW = $clog2(HALF_CYC + 1);

	logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic              aw_have_q, w_have_q, w_en_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [7:0]        w_data_q;
	logic [1:0]        bresp_q, rresp_q;
	logic [31:0]       rdata_q;
	logic              ch_en_q, master_q;
	logic              busy_en_q, auto_ack_q, ack_tx_q, ack_det_q;
	logic              irq_src_q, addr_mask_q, clk_ctrl_q;
	wait_mode_e        wait_mode_q;
	logic [7:0]        saddr_q, shift_q;
	xfer_state_e       state_q;
	logic [3:0]        cnt_q;
	logic              in_bit_q, hi_q, wait_q, match_q, gen_q, irq_q;
	logic [DW-1:0]     div_q;
	logic [2:0]        scl_s_q, sda_s_q;
	logic              scl_lvl_q, sda_lvl_q;
	logic              scl_oe_q, sda_oe_q, scl_o_q, sda_o_q;
	logic              wr_fire, wr_ctrl, wr_sbc, wr_itc, wr_data, wr_saddr, wr_hit;
	logic              start, busy, rise, fall, rise8, rise9, fall8, fall9, stop_det;
	logic              scl_low, sda_low, clock_pin_level;
	logic [7:0]        next_byte, rd_byte;
	logic              rd_hit;

	// AXI4-Lite write path: address and data are taken in either order.
	assign wr_fire  = aw_have_q && w_have_q && !bvalid_q;
	assign wr_ctrl  = wr_fire && w_en_q && aw_addr_q == CTRL_ADDR;
	assign wr_sbc   = wr_fire && w_en_q && aw_addr_q == SBC_ADDR;
	assign wr_itc   = wr_fire && w_en_q && aw_addr_q == ITC_ADDR;
	assign wr_data  = wr_fire && w_en_q && aw_addr_q == DATA_ADDR;
	assign wr_saddr = wr_fire && w_en_q && aw_addr_q == SADDR_ADDR;
	assign wr_hit   = aw_addr_q == CTRL_ADDR || aw_addr_q == SBC_ADDR
		|| aw_addr_q == ITC_ADDR || aw_addr_q == DATA_ADDR
		|| aw_addr_q == SADDR_ADDR || aw_addr_q == STATUS_ADDR;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= REG_RESET;
			w_en_q    <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			awready_q <= awready_q ? !awvalid : (!aw_have_q && !bvalid_q);
			wready_q  <= wready_q ? !wvalid : (!w_have_q && !bvalid_q);
			if (awvalid && awready_q) begin
				aw_addr_q <= awaddr;
				aw_have_q <= 1'b1;
			end else if (wr_fire) begin
				aw_have_q <= 1'b0;
			end
			if (wvalid && wready_q) begin
				w_data_q <= wdata[7:0];
				w_en_q   <= wstrb[0];
				w_have_q <= 1'b1;
			end else if (wr_fire) begin
				w_have_q <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Read path; reserved bits and unmapped words read zero.
	assign clock_pin_level = ch_en_q && scl_lvl_q;

	always_comb begin
		rd_hit  = 1'b1;
		rd_byte = REG_RESET;
		case (araddr)
			CTRL_ADDR:   rd_byte = {ch_en_q, 6'h00, master_q};
			SBC_ADDR:    rd_byte = {busy_en_q, ack_det_q, auto_ack_q, ack_tx_q, 4'h0};
			ITC_ADDR:    rd_byte = {1'b0, clock_pin_level, irq_src_q, addr_mask_q, clk_ctrl_q, 1'b0,
				wait_mode_q};
			DATA_ADDR:   rd_byte = shift_q;
			SADDR_ADDR:  rd_byte = saddr_q;
			STATUS_ADDR: rd_byte = {5'h00, wait_q, match_q, busy};
			default:     rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= RESP_OKAY;
		end else begin
			arready_q <= arready_q ? !arvalid : !rvalid_q;
			if (arvalid && arready_q) begin
				rvalid_q <= 1'b1;
				rdata_q  <= {24'h000000, rd_byte};
				rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// Software-written configuration.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ch_en_q     <= 1'b0;
			master_q    <= 1'b0;
			busy_en_q   <= 1'b0;
			auto_ack_q  <= 1'b0;
			irq_src_q   <= 1'b0;
			addr_mask_q <= 1'b0;
			clk_ctrl_q  <= 1'b0;
			wait_mode_q <= WAIT_NONE;
			saddr_q     <= REG_RESET;
		end else begin
			if (wr_ctrl) begin
				ch_en_q  <= w_data_q[CTRL_ENABLE];
				master_q <= w_data_q[CTRL_MASTER];
			end
			// Only software changes these two bits; a transfer start leaves them alone.
			if (wr_sbc) begin
				busy_en_q  <= w_data_q[SBC_BUSY_EN];
				auto_ack_q <= w_data_q[SBC_AUTO_ACK];
			end
			if (wr_itc) begin
				irq_src_q   <= w_data_q[ITC_IRQ_SRC];
				addr_mask_q <= w_data_q[ITC_ADDR_MASK];
				clk_ctrl_q  <= w_data_q[ITC_CLK_CTRL];
				// The prohibited wait code is refused and the old mode kept.
				if (w_data_q[ITC_WAIT_HI:ITC_WAIT_LO] != WAIT_BAD) begin
					wait_mode_q <= wait_mode_e'(w_data_q[ITC_WAIT_HI:ITC_WAIT_LO]);
				end
			end
			if (wr_saddr) begin
				saddr_q <= w_data_q;
			end
		end
	end

	// Pin synchronisers; a level counts once the second and third stages agree.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_s_q   <= 3'h7;
			sda_s_q   <= 3'h7;
			scl_lvl_q <= 1'b1;
			sda_lvl_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
			if (scl_s_q[1] == scl_s_q[2]) begin
				scl_lvl_q <= scl_s_q[2];
			end
			if (sda_s_q[1] == sda_s_q[2]) begin
				sda_lvl_q <= sda_s_q[2];
			end
		end
	end

	assign rise     = scl_s_q[1] == scl_s_q[2] && scl_s_q[2] && !scl_lvl_q;
	assign fall     = scl_s_q[1] == scl_s_q[2] && !scl_s_q[2] && scl_lvl_q && hi_q;
	assign stop_det = sda_s_q[1] == sda_s_q[2] && sda_s_q[2] && !sda_lvl_q && scl_lvl_q;
	assign start    = wr_data && ch_en_q;
	assign busy     = state_q != XF_IDLE;
	assign rise8    = rise && state_q == XF_DATA && cnt_q == CNT_BIT7;
	assign rise9    = rise && state_q == XF_ACK && cnt_q == CNT_BYTE;
	assign fall8    = fall && state_q == XF_DATA && cnt_q == CNT_BYTE;
	assign fall9    = fall && state_q == XF_ACK && cnt_q == CNT_ACK;
	assign next_byte = {shift_q[6:0], in_bit_q};

	// Byte sequencer: bits are sampled on rising and shifted on falling clock edges; with no wait the last bit shifts at the 8th rise.
	always_ff @(posedge aclk) begin
		if (!aresetn || !ch_en_q) begin
			state_q  <= XF_IDLE;
			cnt_q    <= 4'h0;
			hi_q     <= 1'b0;
			in_bit_q <= 1'b0;
			shift_q  <= REG_RESET;
			match_q  <= 1'b0;
		end else if (start) begin
			state_q <= XF_DATA;
			cnt_q   <= 4'h0;
			hi_q    <= 1'b0;
			shift_q <= w_data_q;
			match_q <= 1'b0;
		end else begin
			if (rise) begin
				hi_q <= 1'b1;
			end else if (fall) begin
				hi_q <= 1'b0;
			end
			case (state_q)
				XF_DATA: begin
					if (rise) begin
						cnt_q    <= cnt_q + 4'h1;
						in_bit_q <= sda_lvl_q;
						// With no wait selected the byte ends at the 8th rise.
						if (rise8 && wait_mode_q == WAIT_NONE) begin
							state_q <= XF_IDLE;
							shift_q <= {shift_q[6:0], sda_lvl_q};
						end
					end else if (fall) begin
						shift_q <= next_byte;
						if (fall8) begin
							state_q <= XF_ACK;
							if (addr_mask_q) begin
								match_q <= next_byte[7:1] == saddr_q[7:1];
							end else begin
								match_q <= next_byte == saddr_q;
							end
						end
					end
				end
				XF_ACK: begin
					if (rise9) begin
						cnt_q <= CNT_ACK;
					end else if (fall9) begin
						state_q <= XF_IDLE;
					end
				end
				default: state_q <= XF_IDLE;
			endcase
		end
	end

	// Acknowledge bits: a software set wins over the falling-edge clear.
	always_ff @(posedge aclk) begin
		if (!aresetn || !ch_en_q || start) begin
			ack_tx_q  <= 1'b0;
			ack_det_q <= 1'b0;
		end else begin
			if (wr_sbc && w_data_q[SBC_ACK_TX]) begin
				ack_tx_q <= 1'b1;
			end else if (fall) begin
				ack_tx_q <= 1'b0;
			end
			if (rise9 && !sda_lvl_q) begin
				ack_det_q <= 1'b1;
			end
		end
	end

	// Wait: a hardware set in the same cycle as a release is kept.
	always_ff @(posedge aclk) begin
		if (!aresetn || !ch_en_q) begin
			wait_q <= 1'b0;
		end else if ((rise8 && wait_mode_q == WAIT_8) || (rise9 && wait_mode_q == WAIT_9)) begin
			wait_q <= 1'b1;
		end else if (start || (wr_itc && w_data_q[ITC_WAIT_REL])) begin
			wait_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !ch_en_q) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= (rise8 && wait_mode_q != WAIT_9)
				|| (rise9 && wait_mode_q == WAIT_9)
				|| (stop_det && irq_src_q);
		end
	end

	// Master clock generator; it waits for the line to follow, so a stretched clock holds it.
	always_ff @(posedge aclk) begin
		if (!aresetn || !busy || !master_q || wait_q) begin
			gen_q <= 1'b1;
			div_q <= '0;
		end else if (scl_lvl_q == gen_q) begin
			if (div_q == DW'(HALF_CYC - 1)) begin
				div_q <= '0;
				gen_q <= !gen_q;
			end else begin
				div_q <= div_q + DW'(1);
			end
		end
	end

	always_comb begin
		if (!ch_en_q) begin
			scl_low = 1'b0;
		end else if (wait_q) begin
			scl_low = 1'b1;
		end else if (busy) begin
			scl_low = master_q && !gen_q;
		end else begin
			scl_low = !clk_ctrl_q;
		end
	end

	assign sda_low = ch_en_q && (ack_tx_q
		|| (state_q == XF_ACK && auto_ack_q)
		|| (state_q == XF_DATA && !busy_en_q && !shift_q[7]));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			scl_o_q  <= 1'b0;
			sda_o_q  <= 1'b0;
		end else begin
			scl_oe_q <= scl_low;
			sda_oe_q <= sda_low;
			scl_o_q  <= 1'b0;
			sda_o_q  <= 1'b0;
		end
	end

	assign awready           = awready_q;
	assign wready            = wready_q;
	assign bvalid            = bvalid_q;
	assign bresp             = bresp_q;
	assign arready           = arready_q;
	assign rvalid            = rvalid_q;
	assign rdata             = rdata_q;
	assign rresp             = rresp_q;
	assign scl_o             = scl_o_q;
	assign scl_oe            = scl_oe_q;
	assign sda_o             = sda_o_q;
	assign sda_oe            = sda_oe_q;
	assign channel_interrupt = irq_q;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	ack_set_a: assert property (
		wr_sbc && w_data_q[SBC_ACK_TX] && ch_en_q |=> ack_tx_q ##1 (sda_oe_q || !ch_en_q))
		else $error("ack transmit did not pull data low");
	ack_clr_a: assert property (
		!ch_en_q || start |=> !ack_tx_q) else $error("ack transmit not cleared");
	auto_ack_a: assert property (
		state_q == XF_ACK && auto_ack_q && ch_en_q |=> sda_oe_q)
		else $error("automatic acknowledge not driven");
	auto_keep_a: assert property (
		auto_ack_q && !wr_sbc |=> auto_ack_q) else $error("auto ack enable lost");
	ack_det_a: assert property (
		rise9 && !sda_lvl_q && ch_en_q && !start |=> ack_det_q)
		else $error("acknowledge not detected");
	ack_detected_clr_a: assert property (
		start |=> !ack_det_q && busy) else $error("ack detected not cleared");
	busy_gate_a: assert property (
		busy_en_q && !ack_tx_q && state_q == XF_DATA |=> !sda_oe_q)
		else $error("data driven while busy enable set");
	int8_a: assert property (
		rise8 && ch_en_q && wait_mode_q != WAIT_9 |=> irq_q)
		else $error("no interrupt at 8th clock");
	wait9_a: assert property (
		rise9 && ch_en_q && wait_mode_q == WAIT_9 |=> wait_q ##1 (scl_oe_q || !ch_en_q))
		else $error("no wait after 9th clock");
	wait_rel_a: assert property (
		wr_itc && w_data_q[ITC_WAIT_REL] && !rise8 && !rise9 |=> !wait_q)
		else $error("wait not released");
	idle_low_a: assert property (
		ch_en_q && !busy && !wait_q && !clk_ctrl_q |=> scl_oe_q)
		else $error("idle clock not driven low");
	cld_off_a: assert property (
		!ch_en_q |-> !clock_pin_level) else $error("clock level visible while disabled");

endmodule

// file: tb/twowire_partner.sv
// Behavioural external bus master that clocks bytes through the channel.
`timescale 1ns/10ps
module twowire_partner (
	input  wire logic dut_scl_oe,
	input  wire logic dut_sda_oe,
	output logic      scl,
	output logic      sda
);
	logic       pull_scl;
	logic       pull_sda;
	logic [8:0] rx;

	// Both lines have pull-ups, so a line that nobody pulls reads high.
	assign scl = !(dut_scl_oe | pull_scl);
	assign sda = !(dut_sda_oe | pull_sda);

	initial begin
		pull_scl = 1'b0;
		pull_sda = 1'b0;
		rx       = 9'h000;
	end

	// Clocks n bits MSB first from tx[8] and ends with the clock held low.
	// Data only moves while the clock is low, so no start or stop is made.
	task automatic clock_bits(input logic [8:0] tx, input int n);
		int t;
		// Keep every pin change off the sampling clock edge.
		#1;
		for (int i = 0; i < n; i++) begin
			pull_scl = 1'b1;
			#4;
			pull_sda = !tx[8 - i];
			#20;
			pull_scl = 1'b0;
			t = 0;
			// A device that stretches the clock is waited for, within a bound.
			while (scl !== 1'b1 && t < 2000) begin
				#1;
				t++;
			end
			rx = {rx[7:0], sda};
			#24;
			pull_scl = 1'b1;
		end
	endtask

	task automatic release_bus();
		#1;
		pull_sda = 1'b0;
		#24;
		pull_scl = 1'b0;
	endtask

	// Data rises while the clock is high, which every device on the bus sees as a stop.
	task automatic stop_cond();
		#1;
		pull_scl = 1'b1;
		#24;
		pull_sda = 1'b1;
		#24;
		pull_scl = 1'b0;
		#24;
		pull_sda = 1'b0;
		#24;
	endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the two-wire acknowledge, wait and clock-level block.
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
	import twowire_pkg::*;
	logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata, rd_v;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, rd_r, wr_r;
	logic              awready, wready, bvalid, arready, rvalid;
	logic              scl, sda, scl_oe, sda_oe, scl_o, sda_o, channel_interrupt;
	logic [31:0]       rs;
	logic [7:0]        d1, d2;
	int                n_mismatch, check_count, n_irq;

	twowire_ack_wait_control #(.HALF_CYC(6)) dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .channel_interrupt(channel_interrupt));

	twowire_partner bus_model (.dut_scl_oe(scl_oe), .dut_sda_oe(sda_oe), .scl(scl), .sda(sda));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Expected read-back of the timing register after a write with the channel off.
	function automatic logic [7:0] itc_exp(input logic [7:0] w, input logic [1:0] old);
		return {2'b00, w[5:3], 1'b0, (w[1:0] == 2'b01) ? old : w[1:0]};
	endfunction

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) n_irq <= 0;
		else if (channel_interrupt === 1'b1) n_irq <= n_irq + 1;
	end

	task automatic wr(input logic [17:0] a, input logic [7:0] d);
		logic done;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= {24'h000000, d};
		wstrb   <= 4'hF;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		done = 1'b0;
		// Only the watchdog ends a wait for the slave's answer.
		while (!done) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				bready <= 1'b0;
				wr_r = bresp;
				done = 1'b1;
			end
		end
	endtask

	task automatic rd(input logic [17:0] a);
		logic done;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				rready <= 1'b0;
				rd_v = rdata;
				rd_r = rresp;
				done = 1'b1;
			end
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#100000;
		n_mismatch++;
		finish_test();
	end

	initial begin
		n_mismatch = 0;
		check_count = 0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 18'h00000;
		araddr = 18'h00000;
		wdata = 32'h00000000;
		wstrb = 4'h0;
		rs = 32'hBBBBA6E2;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(CTRL_ADDR);
		`CHK(rd_v[7:0], REG_RESET)
		`CHK(rd_r, RESP_OKAY)
		rd(SBC_ADDR);
		`CHK(rd_v[7:0], REG_RESET)
		rd(ITC_ADDR);
		`CHK(rd_v[7:0], REG_RESET)
		rd(18'h00000);
		`CHK(rd_r, RESP_SLVERR)
		wr(18'h00004, 8'hFF);
		`CHK(wr_r, RESP_SLVERR)
		wr(ITC_ADDR, 8'h7F);
		`CHK(wr_r, RESP_OKAY)
		rd(ITC_ADDR);
		`CHK(rd_v[7:0], itc_exp(8'h7F, 2'b00))
		wr(ITC_ADDR, 8'h39);
		rd(ITC_ADDR);
		`CHK(rd_v[7:0], itc_exp(8'h39, 2'b11))
		wr(CTRL_ADDR, 8'h80);
		wr(ITC_ADDR, 8'h03);
		repeat (8) @(posedge aclk);
		`CHK(scl_oe, 1'b1)
		wr(ITC_ADDR, 8'h0B);
		repeat (8) @(posedge aclk);
		`CHK(scl_oe, 1'b0)
		rd(ITC_ADDR);
		`CHK(rd_v[7:0], 8'h4B)
		rs = xs(rs);
		d1 = rs[7:0];
		rs = xs(rs);
		d2 = rs[7:0];
		// Auto acknowledge is set up before the transfer starts.
		wr(SBC_ADDR, 8'h20);
		wr(DATA_ADDR, d1);
		bus_model.clock_bits(9'h1FF, 9);
		repeat (8) @(posedge aclk);
		`CHK(bus_model.rx, {d1, 1'b0})
		`CHK(n_irq, 1)
		`CHK(scl_oe, 1'b1)
		rd(SBC_ADDR);
		`CHK(rd_v[7:0], 8'h60)
		wr(ITC_ADDR, 8'h0F);
		repeat (8) @(posedge aclk);
		`CHK(scl_oe, 1'b0)
		bus_model.release_bus();
		wr(SBC_ADDR, 8'h80);
		wr(SADDR_ADDR, d2 ^ 8'h01);
		wr(ITC_ADDR, 8'h1A);
		wr(DATA_ADDR, 8'h00);
		rd(SBC_ADDR);
		`CHK(rd_v[7:0], 8'h80)
		bus_model.clock_bits({d2, 1'b1}, 8);
		repeat (8) @(posedge aclk);
		`CHK(n_irq, 2)
		`CHK(scl_oe, 1'b1)
		`CHK(sda_oe, 1'b0)
		rd(DATA_ADDR);
		`CHK(rd_v[7:0], d2)
		// Masked compare ignores bit 0, so the address differing only there matches.
		rd(STATUS_ADDR);
		`CHK(rd_v[7:0], 8'h07)
		// In 8-clock wait the receive acknowledge comes from software.
		wr(SBC_ADDR, 8'h90);
		repeat (2) @(posedge aclk);
		`CHK(sda_oe, 1'b1)
		wr(ITC_ADDR, 8'h0E);
		repeat (8) @(posedge aclk);
		`CHK(scl_oe, 1'b0)
		bus_model.clock_bits(9'h100, 1);
		repeat (8) @(posedge aclk);
		`CHK(bus_model.rx[0], 1'b0)
		`CHK(sda_oe, 1'b0)
		`CHK(n_irq, 2)
		rd(SBC_ADDR);
		`CHK(rd_v[7:0], 8'hC0)
		bus_model.release_bus();
		bus_model.stop_cond();
		repeat (8) @(posedge aclk);
		`CHK(n_irq, 2)
		wr(ITC_ADDR, 8'h28);
		bus_model.stop_cond();
		repeat (8) @(posedge aclk);
		`CHK(n_irq, 3)
		// Stop interrupts go off again: the ack release below would read as a stop.
		wr(ITC_ADDR, 8'h08);
		wr(CTRL_ADDR, 8'h81);
		wr(SBC_ADDR, 8'h90);
		wr(DATA_ADDR, 8'h00);
		rd(SBC_ADDR);
		`CHK(rd_v[7:0], 8'h80)
		`CHK(sda_oe, 1'b0)
		// As master with no wait selected, the byte ends at the 8th rise.
		repeat (300) @(posedge aclk);
		`CHK(n_irq, 4)
		`CHK(scl_oe, 1'b0)
		rd(STATUS_ADDR);
		`CHK(rd_v[7:0], 8'h00)
		wr(ITC_ADDR, 8'h20);
		wr(CTRL_ADDR, 8'h00);
		rd(ITC_ADDR);
		`CHK(rd_v[7:0], 8'h20)
		`CHK({scl_oe, sda_oe}, 2'b00)
		`CHK({scl_o, sda_o}, 2'b00)
		finish_test();
	end
endmodule
